/* shared/fsi_pkg.sv */
// constants and types for the flame status indicator driver
// Operation
// [R1] function light steady green while mains present and scanner supply lies in window
// [R2] flame-strength row shows scanner condition only while function light is green
// [R3] supply outside window flashes the function light red as internal fault
// [R4] during supply fault all row lights dark and scanner power output off
// [R5] row is eight separately driven multi-colour lights, index 0 leftmost
// [R6] flame off lights only leftmost position red, other seven dark
// [R7] flame on lights two to eight green from the left, rising with strength
// [R8] warning mode alternates left four yellow with right four yellow
// [R9] scanner fault mode flashes all eight row lights yellow together
// [R10] scanner disabled mode holds all eight row lights steady yellow
// [R11] no scanner signals detected turns all eight row lights off
// [R12] sixteen-light ring mirrors the scanner ring in every mode
// [R13] scanner condition decoded from both loop currents, selecting all patterns
// [R14] fault contact closes to its common when a scanner problem is seen
// [R15] flash and alternation rates are parameters derived from the system clock
package fsi_pkg;

  // system clock
  localparam int unsigned CLK_KHZ         = 10000;

  // light colour codes, two bits per light
  localparam logic [1:0]  COL_OFF         = 2'h0;
  localparam logic [1:0]  COL_RED         = 2'h1;
  localparam logic [1:0]  COL_GREEN       = 2'h2;
  localparam logic [1:0]  COL_YELLOW      = 2'h3;

  // row and ring geometry
  localparam int unsigned ROW_LIGHTS      = 8;
  localparam int unsigned RING_LIGHTS     = 16;
  localparam int unsigned FLAME_ON_MIN    = 2;

  // fixed row patterns, light 0 in bits [1:0]
  localparam logic [15:0] ROW_DARK        = 16'h0000;
  localparam logic [15:0] ROW_FLAME_OFF   = 16'h0001;
  localparam logic [15:0] ROW_ALL_YELLOW  = 16'hffff;
  localparam logic [15:0] ROW_LEFT_YELLOW = 16'h00ff;
  localparam logic [15:0] ROW_RIGHT_YELLOW= 16'hff00;

  // loop current codes (8-bit converter samples) separating the conditions
  localparam logic [7:0]  LOOP_ABSENT_MAX = 8'h10;
  localparam logic [7:0]  LOOP_B_DIS_MAX  = 8'h40;
  localparam logic [7:0]  LOOP_B_FLT_MAX  = 8'h70;
  localparam logic [7:0]  LOOP_B_WARN_MAX = 8'ha0;
  localparam logic [7:0]  LOOP_B_OFF_MAX  = 8'hd0;
  localparam logic [7:0]  LOOP_A_ON_BASE  = 8'h30;
  localparam int unsigned LOOP_A_STEP_SH  = 5;

  // times in milliseconds and their cycle counts
  localparam int unsigned FLASH_HALF_MS   = 500;
  localparam int unsigned ALT_HALF_MS     = 500;
  localparam int unsigned RETRY_MS        = 1000;
  localparam int unsigned SETTLE_MS       = 50;
  localparam int unsigned FLASH_HALF_CYC  = FLASH_HALF_MS * CLK_KHZ;
  localparam int unsigned ALT_HALF_CYC    = ALT_HALF_MS * CLK_KHZ;
  localparam int unsigned RETRY_CYC       = RETRY_MS * CLK_KHZ;
  localparam int unsigned SETTLE_CYC      = SETTLE_MS * CLK_KHZ;

  // scanner conditions
  typedef enum logic [2:0] {
    MD_NONE,
    MD_DISABLED,
    MD_FAULT,
    MD_WARN,
    MD_FLAME_OFF,
    MD_FLAME_ON
  } fsi_mode_t;

endpackage : fsi_pkg

/* hw/fsi_phase_div.sv */
// free-running divider giving a square phase for flashing and alternation
`timescale 1ns/100ps
module fsi_phase_div
  import fsi_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = FLASH_HALF_CYC
)
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  // phase out
  output logic      o_phase
);

  localparam int unsigned CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          phase_reg;
  logic          phase_next;

  always_comb
  begin
    cnt_next   = cnt_reg + 1'b1;
    phase_next = phase_reg;
    if (cnt_reg == LAST)
    begin
      cnt_next   = '0;
      phase_next = ~phase_reg;  // [R15]
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cnt_reg   <= '0;
      phase_reg <= 1'b0;
    end
    else
    begin
      cnt_reg   <= cnt_next;
      phase_reg <= phase_next;
    end
  end

  assign o_phase = phase_reg;

endmodule : fsi_phase_div

/* hw/fsi_top.sv */
// flame status indicator driver: supply check, condition decode, light patterns
`timescale 1ns/100ps
module fsi_top
  import fsi_pkg::*;
#(
  parameter int unsigned FLASH_CYCLES  = FLASH_HALF_CYC,
  parameter int unsigned ALT_CYCLES    = ALT_HALF_CYC,
  parameter int unsigned RETRY_CYCLES  = RETRY_CYC,
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
)
(
  // clock and reset
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RESET_N,
  // supply monitor pins
  input  wire logic        I_MAINS_OK,
  input  wire logic        I_VOUT_IN_WINDOW,
  // loop current samples from the converter, same clock
  input  wire logic        I_LOOP_SAMPLE_VALID,
  input  wire logic [7:0]  I_SCANNER_LOOP_CURRENT_A,
  input  wire logic [7:0]  I_SCANNER_LOOP_CURRENT_B,
  // indicators
  output logic [1:0]       O_FUNC_LED,
  output logic [15:0]      O_ROW_LED,
  output logic [31:0]      O_RING_LED,
  // power and fault contact
  output logic             O_SCANNER_PWR_EN,
  output logic             O_FAULT_CONTACT_CLOSE
);

  localparam int unsigned RW = $clog2(RETRY_CYCLES + 1);
  localparam int unsigned SW = $clog2(SETTLE_CYCLES + 1);
  localparam logic [RW-1:0] RETRY_LAST  = RW'(RETRY_CYCLES - 1);
  localparam logic [SW-1:0] SETTLE_LAST = SW'(SETTLE_CYCLES - 1);

  // pin synchronisers: three stages, a change counts once stages two and three agree
  logic [2:0] mains_sync_reg;
  logic [2:0] vout_sync_reg;
  logic       mains_ok_reg;
  logic       mains_ok_next;
  logic       vout_ok_reg;
  logic       vout_ok_next;

  always_comb
  begin
    mains_ok_next = mains_ok_reg;
    vout_ok_next  = vout_ok_reg;
    if (mains_sync_reg[1] == mains_sync_reg[2])
    begin
      mains_ok_next = mains_sync_reg[2];
    end
    if (vout_sync_reg[1] == vout_sync_reg[2])
    begin
      vout_ok_next = vout_sync_reg[2];
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      // start at the pins' good level, so a healthy power-up never flashes a false fault
      mains_sync_reg <= 3'h7;
      vout_sync_reg  <= 3'h7;
      mains_ok_reg   <= 1'b1;
      vout_ok_reg    <= 1'b1;
    end
    else
    begin
      mains_sync_reg <= {mains_sync_reg[1:0], I_MAINS_OK};
      vout_sync_reg  <= {vout_sync_reg[1:0], I_VOUT_IN_WINDOW};
      mains_ok_reg   <= mains_ok_next;
      vout_ok_reg    <= vout_ok_next;
    end
  end

  // supply supervision; the window is ignored while the output settles,
  // otherwise switching power off would hold the fault forever
  logic          supply_fault_reg;
  logic          supply_fault_next;
  logic [RW-1:0] retry_cnt_reg;
  logic [RW-1:0] retry_cnt_next;
  logic [SW-1:0] settle_cnt_reg;
  logic [SW-1:0] settle_cnt_next;
  logic          settle_done;

  assign settle_done = (settle_cnt_reg == '0);

  always_comb
  begin
    supply_fault_next = supply_fault_reg;
    retry_cnt_next    = retry_cnt_reg;
    settle_cnt_next   = settle_cnt_reg;
    if (!supply_fault_reg)
    begin
      if (!settle_done)
      begin
        settle_cnt_next = settle_cnt_reg - 1'b1;
      end
      if (!mains_ok_reg || (settle_done && !vout_ok_reg))
      begin
        supply_fault_next = 1'b1;  // [R3]
        retry_cnt_next    = RETRY_LAST;
        settle_cnt_next   = '0;
      end
    end
    else if (retry_cnt_reg != '0)
    begin
      retry_cnt_next = retry_cnt_reg - 1'b1;
    end
    else if (mains_ok_reg)
    begin
      supply_fault_next = 1'b0;
      settle_cnt_next   = SETTLE_LAST;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      supply_fault_reg <= 1'b0;
      retry_cnt_reg    <= '0;
      settle_cnt_reg   <= SETTLE_LAST;
    end
    else
    begin
      supply_fault_reg <= supply_fault_next;
      retry_cnt_reg    <= retry_cnt_next;
      settle_cnt_reg   <= settle_cnt_next;
    end
  end

  // flash and alternation phases
  logic flash_phase;
  logic alt_phase;

  fsi_phase_div #(.HALF_CYCLES(FLASH_CYCLES)) u_flash_div (  // [R15]
    .i_clk    (I_CLK_SYS),
    .i_reset_n(I_RESET_N),
    .o_phase  (flash_phase)
  );

  fsi_phase_div #(.HALF_CYCLES(ALT_CYCLES)) u_alt_div (  // [R15]
    .i_clk    (I_CLK_SYS),
    .i_reset_n(I_RESET_N),
    .o_phase  (alt_phase)
  );

  // condition decode from both loops
  fsi_mode_t  mode_reg;
  fsi_mode_t  mode_next;
  logic [3:0] lit_reg;
  logic [3:0] lit_next;
  logic [7:0] a_over;

  assign a_over = (I_SCANNER_LOOP_CURRENT_A > LOOP_A_ON_BASE) ?
                  (I_SCANNER_LOOP_CURRENT_A - LOOP_A_ON_BASE) : 8'h00;

  always_comb
  begin
    mode_next = mode_reg;
    lit_next  = lit_reg;
    if (I_LOOP_SAMPLE_VALID)
    begin
      if (I_SCANNER_LOOP_CURRENT_A <= LOOP_ABSENT_MAX &&
          I_SCANNER_LOOP_CURRENT_B <= LOOP_ABSENT_MAX)
        mode_next = MD_NONE;  // [R13] [R11]
      else if (I_SCANNER_LOOP_CURRENT_B <= LOOP_B_DIS_MAX)
        mode_next = MD_DISABLED;  // [R13]
      else if (I_SCANNER_LOOP_CURRENT_B <= LOOP_B_FLT_MAX)
        mode_next = MD_FAULT;
      else if (I_SCANNER_LOOP_CURRENT_B <= LOOP_B_WARN_MAX)
        mode_next = MD_WARN;
      else if (I_SCANNER_LOOP_CURRENT_B <= LOOP_B_OFF_MAX)
        mode_next = MD_FLAME_OFF;
      else
        mode_next = MD_FLAME_ON;
      // strength: two lights at the base, one more per step, capped at eight
      if ((a_over >> LOOP_A_STEP_SH) >= 8'(ROW_LIGHTS - FLAME_ON_MIN))
        lit_next = 4'(ROW_LIGHTS);  // [R7]
      else
        lit_next = 4'(FLAME_ON_MIN) + 4'(a_over >> LOOP_A_STEP_SH);
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      mode_reg <= MD_NONE;
      lit_reg  <= 4'(FLAME_ON_MIN);
    end
    else
    begin
      mode_reg <= mode_next;
      lit_reg  <= lit_next;
    end
  end

  // light patterns; outside warning mode the row doubles as the left half of the ring
  logic [1:0]  func_next;
  logic [15:0] row_next;
  logic [15:0] scan_row;
  logic [15:0] ring_right;
  logic        fault_contact_next;

  always_comb
  begin
    scan_row   = ROW_DARK;
    ring_right = ROW_DARK;
    case (mode_reg)
      MD_FLAME_OFF: scan_row = ROW_FLAME_OFF;  // [R6]
      MD_FLAME_ON:
      begin
        for (int i = 0; i < ROW_LIGHTS; i++)
        begin
          if (i < int'(lit_reg))
            scan_row[2*i +: 2] = COL_GREEN;  // [R5] [R7]
        end
      end
      MD_WARN:
      begin
        scan_row   = alt_phase ? ROW_RIGHT_YELLOW : ROW_LEFT_YELLOW;  // [R8]
        ring_right = alt_phase ? ROW_ALL_YELLOW : ROW_DARK;  // [R12]
      end
      MD_FAULT:
      begin
        scan_row   = flash_phase ? ROW_ALL_YELLOW : ROW_DARK;  // [R9]
        ring_right = scan_row;  // [R12]
      end
      MD_DISABLED:
      begin
        scan_row   = ROW_ALL_YELLOW;  // [R10]
        ring_right = ROW_ALL_YELLOW;  // [R12]
      end
      MD_NONE: scan_row = ROW_DARK;  // [R11]
      default: scan_row = ROW_DARK;
    endcase
    if (supply_fault_reg)
    begin
      func_next  = flash_phase ? COL_RED : COL_OFF;  // [R3]
      row_next   = ROW_DARK;  // [R4]
      ring_right = ROW_DARK;
    end
    else
    begin
      func_next = COL_GREEN;  // [R1]
      row_next  = scan_row;  // [R2]
    end
    fault_contact_next = (mode_reg == MD_FAULT) || (mode_reg == MD_NONE) ||
                         (mode_reg == MD_WARN);  // [R14]
  end

  // in warning mode the ring swaps its eight-light halves while the row swaps its four-light halves
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      O_FUNC_LED            <= COL_OFF;
      O_ROW_LED             <= ROW_DARK;
      O_RING_LED            <= 32'h0000_0000;
      O_SCANNER_PWR_EN      <= 1'b0;
      O_FAULT_CONTACT_CLOSE <= 1'b1;
    end
    else
    begin
      O_FUNC_LED            <= func_next;
      O_ROW_LED             <= row_next;
      O_RING_LED            <= (mode_reg == MD_WARN && !supply_fault_reg) ?
                               {ring_right, ~ring_right} : {ring_right, row_next};  // [R12]
      O_SCANNER_PWR_EN      <= !supply_fault_reg;  // [R4]
      O_FAULT_CONTACT_CLOSE <= fault_contact_next;  // [R14]
    end
  end

  // checks
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESET_N);

  sequence s_window_lost;
    (!I_VOUT_IN_WINDOW && I_MAINS_OK && settle_done && !supply_fault_reg)[*5];
  endsequence

  sequence s_in_mode(fsi_mode_t m);
    !supply_fault_reg && mode_reg == m;
  endsequence

  AST_FUNC_GREEN: assert property ($past(I_RESET_N) && !$past(supply_fault_reg) |-> // [R1]
      O_FUNC_LED == COL_GREEN)
    else $error("function light not green while supply good");
  AST_ROW_ONLY_GOOD: assert property (O_ROW_LED != ROW_DARK |-> O_FUNC_LED == COL_GREEN) // [R2]
    else $error("row lit while supply not good");
  AST_FAULT_DETECT: assert property (s_window_lost |-> ##[1:3] supply_fault_reg) // [R3]
    else $error("supply fault not raised after window lost");
  AST_FUNC_RED: assert property ($past(supply_fault_reg) |->
      O_FUNC_LED == ($past(flash_phase) ? COL_RED : COL_OFF)) // [R3]
    else $error("function light not flashing red in supply fault");
  AST_PWR_OFF: assert property (supply_fault_reg |=>
      !O_SCANNER_PWR_EN && O_ROW_LED == ROW_DARK) // [R4]
    else $error("power or row still on in supply fault");
  AST_FLAME_OFF: assert property (s_in_mode(MD_FLAME_OFF) |=> O_ROW_LED == ROW_FLAME_OFF) // [R6]
    else $error("flame off pattern wrong");
  AST_FLAME_ON: assert property (s_in_mode(MD_FLAME_ON) |=> O_ROW_LED inside
      {16'h000a, 16'h002a, 16'h00aa, 16'h02aa, 16'h0aaa, 16'h2aaa, 16'haaaa}) // [R7]
    else $error("flame on pattern not a left-aligned green run");
  AST_WARN_ALT: assert property (s_in_mode(MD_WARN) |=>
      O_ROW_LED == ($past(alt_phase) ? ROW_RIGHT_YELLOW : ROW_LEFT_YELLOW)) // [R8]
    else $error("warning halves not alternating");
  AST_FAULT_FLASH: assert property (s_in_mode(MD_FAULT) |=>
      O_ROW_LED == ($past(flash_phase) ? ROW_ALL_YELLOW : ROW_DARK)) // [R9]
    else $error("fault row not flashing yellow");
  AST_DISABLED: assert property (s_in_mode(MD_DISABLED) |=> O_ROW_LED == ROW_ALL_YELLOW) // [R10]
    else $error("disabled row not steady yellow");
  AST_NO_SCANNER: assert property (mode_reg == MD_NONE |=> O_ROW_LED == ROW_DARK) // [R11]
    else $error("row lit with no scanner");
  AST_RING_LEFT: assert property ((supply_fault_reg || mode_reg != MD_WARN) |=> // [R12]
      O_RING_LED[15:0] == O_ROW_LED)
    else $error("ring left half does not mirror row");
  AST_DECODE_NONE: assert property (I_LOOP_SAMPLE_VALID &&
      I_SCANNER_LOOP_CURRENT_A <= LOOP_ABSENT_MAX && I_SCANNER_LOOP_CURRENT_B <= LOOP_ABSENT_MAX
      |=> mode_reg == MD_NONE ##1 O_FAULT_CONTACT_CLOSE) // [R13]
    else $error("absent loops not decoded as no scanner");
  AST_CONTACT: assert property (mode_reg == MD_FAULT |=> O_FAULT_CONTACT_CLOSE) // [R14]
    else $error("fault contact open in scanner fault");

endmodule : fsi_top

/* test/fsi_scanner_model.sv */
// scanner model: turns a requested condition into one pair of loop samples
`timescale 1ns/100ps
module fsi_scanner_model
  import fsi_pkg::*;
(
  // clock
  input  wire logic       i_clk,
  // request from the bench
  input  wire logic       i_send,
  input  wire fsi_mode_t  i_mode,
  input  wire logic [3:0] i_lit,
  // converter samples
  output logic            o_valid,
  output logic [7:0]      o_loop_a,
  output logic [7:0]      o_loop_b
);
  logic [7:0] a_code;
  logic [7:0] b_code;

  // mid-band loop B codes keep clear of the decode boundaries; loop A strength codes sit on step starts
  always_comb
  begin
    a_code = (i_mode == MD_NONE) ? 8'h00 : 8'h80;
    if (i_mode == MD_FLAME_ON)
      a_code = 8'h30 + (({4'h0, i_lit} - 8'h02) << 5);
    case (i_mode)
      MD_DISABLED:  b_code = 8'h30;
      MD_FAULT:     b_code = 8'h60;
      MD_WARN:      b_code = 8'h90;
      MD_FLAME_OFF: b_code = 8'hc0;
      MD_FLAME_ON:  b_code = 8'hf0;
      default:      b_code = 8'h00;
    endcase
  end

  initial
  begin
    o_valid  = 1'b0;
    o_loop_a = 8'h5a;
    o_loop_b = 8'ha5;
  end

  // both loops move together; between samples the codes toggle as a
  // converter would give no stable value there
  always @(posedge i_clk)
  begin
    o_valid  <= i_send;
    o_loop_a <= i_send ? a_code : ~o_loop_a;
    o_loop_b <= i_send ? b_code : ~o_loop_b;
  end
endmodule : fsi_scanner_model

/* test/test_flame_status_indicator_driver.sv */
// self-checking bench for the flame status indicator driver
`timescale 1ns/100ps
module test_flame_status_indicator_driver;
  import fsi_pkg::*;

  // short counts keep the run brief
  localparam int unsigned FL = 4;
  localparam int unsigned RT = 20;

  logic        clk;
  logic        rst_n;
  logic        mains_ok;
  logic        vout_ok;
  logic        send;
  fsi_mode_t   mode;
  logic [3:0]  lit;
  logic        s_valid;
  logic [7:0]  s_a;
  logic [7:0]  s_b;
  logic [1:0]  func_led;
  logic [15:0] row_led;
  logic [31:0] ring_led;
  logic        pwr_en;
  logic        contact;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  fsi_top #(.FLASH_CYCLES(FL), .ALT_CYCLES(FL), .RETRY_CYCLES(RT), .SETTLE_CYCLES(8)) fsi_top_i (
    .I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_MAINS_OK(mains_ok), .I_VOUT_IN_WINDOW(vout_ok),
    .I_LOOP_SAMPLE_VALID(s_valid), .I_SCANNER_LOOP_CURRENT_A(s_a),
    .I_SCANNER_LOOP_CURRENT_B(s_b), .O_FUNC_LED(func_led), .O_ROW_LED(row_led),
    .O_RING_LED(ring_led), .O_SCANNER_PWR_EN(pwr_en), .O_FAULT_CONTACT_CLOSE(contact));

  fsi_scanner_model fsi_scanner_model_i (
    .i_clk(clk), .i_send(send), .i_mode(mode), .i_lit(lit),
    .o_valid(s_valid), .o_loop_a(s_a), .o_loop_b(s_b));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    $display("mismatches %0d, comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic show(input fsi_mode_t m, input logic [3:0] n);
    @(posedge clk);
    mode <= m;
    lit  <= n;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    repeat (6) @(negedge clk);
  endtask : show

  task automatic wait_green;
    int n;
    n = 0;
    while (func_led !== COL_GREEN && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    check("function light", func_led, COL_GREEN);
    check("scanner power", pwr_en, 1'b1);
  endtask : wait_green

  task automatic t_steady(input fsi_mode_t m, input logic [15:0] row, input logic [31:0] ring,
                          input logic cl);
    show(m, 4'h0);
    check("row", row_led, row);
    check("ring", ring_led, ring);
    check("fault contact", contact, cl);
  endtask : t_steady

  task automatic t_flame_on;
    logic [15:0] exp;
    for (int n = 2; n <= 8; n++)
    begin
      show(MD_FLAME_ON, 4'(n));
      exp = 16'haaaa & 16'((32'h1 << (2 * n)) - 1);
      check("flame on row", row_led, exp);
      check("flame on ring", ring_led, {16'h0000, exp});
      check("flame on contact", contact, 1'b0);
    end
  endtask : t_flame_on

  // two frames must each take exactly half of two full periods
  task automatic t_blink(input fsi_mode_t m, input logic [15:0] ra, input logic [31:0] ga,
                         input logic [15:0] rb, input logic [31:0] gb);
    int a;
    int b;
    int other;
    show(m, 4'h0);
    a = 0;
    b = 0;
    other = 0;
    repeat (4 * FL)
    begin
      @(negedge clk);
      if (row_led === ra && ring_led === ga)
        a++;
      else if (row_led === rb && ring_led === gb)
        b++;
      else
        other++;
    end
    check("blink odd frames", other, 0);
    check("blink first frames", a, 2 * FL);
    check("blink second frames", b, 2 * FL);
    check("blink contact", contact, 1'b1);
  endtask : t_blink

  task automatic t_supply;
    int n;
    int red;
    int lit_row;
    show(MD_DISABLED, 4'h0);
    @(posedge clk);
    vout_ok <= 1'b0;
    n = 0;
    while (pwr_en !== 1'b0 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    check("power off on fault", pwr_en, 1'b0);
    red = 0;
    lit_row = 0;
    repeat (2 * FL)
    begin
      @(negedge clk);
      red += (func_led === COL_RED);
      lit_row += (row_led !== ROW_DARK);
      check("fault light not green", func_led === COL_GREEN, 1'b0);
    end
    check("red flash frames", red, FL);
    check("row lit in fault", lit_row, 0);
    @(posedge clk);
    vout_ok <= 1'b1;
    wait_green();
    repeat (4) @(negedge clk);
    check("row back", row_led, ROW_ALL_YELLOW);
  endtask : t_supply

  task automatic t_mains;
    @(posedge clk);
    mains_ok <= 1'b0;
    repeat (12) @(negedge clk);
    check("green without mains", func_led === COL_GREEN, 1'b0);
    @(posedge clk);
    mains_ok <= 1'b1;
    wait_green();
  endtask : t_mains

  initial
  begin
    rst_n = 1'b0;
    mains_ok = 1'b1;
    vout_ok = 1'b1;
    send = 1'b0;
    mode = MD_NONE;
    lit = 4'h0;
    repeat (3) @(negedge clk);
    check("contact in reset", contact, 1'b1);
    @(posedge clk);
    rst_n <= 1'b1;
    wait_green();
    t_steady(MD_NONE, ROW_DARK, 32'h0, 1'b1);
    t_steady(MD_DISABLED, ROW_ALL_YELLOW, 32'hffffffff, 1'b0);
    t_steady(MD_FLAME_OFF, ROW_FLAME_OFF, 32'h00000001, 1'b0);
    t_flame_on();
    t_blink(MD_WARN, ROW_LEFT_YELLOW, 32'h0000ffff, ROW_RIGHT_YELLOW, 32'hffff0000);
    t_blink(MD_FAULT, ROW_DARK, 32'h0, ROW_ALL_YELLOW, 32'hffffffff);
    t_supply();
    t_mains();
    give_verdict();
  end
endmodule : test_flame_status_indicator_driver
